// [bench/dpa_cmd_src.sv]
`timescale 1ns/100ps
module dpa_cmd_src (
  // Clock
  input wire logic               sys_clk,
  // Transfer events
  output dpa_pkg::dpa_event_type evt
);
  import dpa_pkg::*;
  initial evt = '0;
  task automatic issue(input logic [7:0] id);
    @(posedge sys_clk);
    evt <= '{xfer_done: 1'b1, is_reg: 1'b0, master_id: id};
    @(posedge sys_clk);
    evt.xfer_done <= 1'b0;
  endtask : issue
endmodule : dpa_cmd_src

// [bench/dpa_ctrl_sva.sv]
`timescale 1ns/100ps
module dpa_ctrl_chk (
  // Clock and reset
  input wire logic                   sys_clk,
  input wire logic                   rst,
  // Observed ports
  input wire dpa_pkg::dpa_bus_type   bus,
  input wire logic [31:0]            rdata,
  input wire dpa_pkg::dpa_event_type evt,
  input wire dpa_pkg::dpa_policy_type policy
);
  import dpa_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  chk_init_pulse: assert property (
    bus.wr && bus.addr == 8'h3c |=> policy.init_start)
    else $error("init start missing");
  chk_init_cause: assert property (
    policy.init_start |-> $past(bus.wr) && $past(bus.addr) == 8'h3c)
    else $error("init start without write");
  chk_boost_cause: assert property (
    policy.boost_oldest |-> $past(evt.xfer_done))
    else $error("boost without transfer");
  chk_boost_single: assert property (
    policy.boost_oldest && policy.open_row_first |=> !policy.boost_oldest)
    else $error("boost too long");
  chk_row_range: assert property (
    policy.row_bits >= 5'h09 && policy.row_bits <= 5'h10)
    else $error("row bits out of range");
  chk_refresh_resv: assert property (
    policy.refresh_reserved |-> policy.refresh_eighths == 5'h00)
    else $error("reserved code covers banks");
  chk_eighths_set: assert property (
    policy.refresh_eighths inside {5'h00, 5'h01, 5'h02, 5'h04, 5'h08})
    else $error("bad refresh coverage");
  chk_open_row: assert property (
    bus.wr && bus.addr == 8'h20 |=>
      policy.open_row_first == ($past(bus.wdata[7:0]) != 8'h00))
    else $error("open row policy wrong");
endmodule : dpa_ctrl_chk

// [bench/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
  import dpa_pkg::*;
  logic           sys_clk;
  logic           rst;
  dpa_bus_type    bus;
  logic [31:0]    rdata;
  logic [31:0]    d;
  dpa_event_type  evt;
  dpa_policy_type policy;
  int             miscompares;
  int             num_checks;
  int             boosts;
  // Address, write data, readback
  logic [31:0] rows [7][3] = '{'{32'h08, 32'hffffffff, 32'h00000020},
    '{32'h3c, 32'hffffffff, 32'h00070007},
    '{32'h20, 32'h000000ff, 32'h000000ff},
    '{32'h48, 32'hffffffff, 32'hc00fc00f},
    '{32'h4c, 32'hffffffff, 32'hffffffff},
    '{32'h40, 32'hffffffff, 32'h00000000},
    '{32'h10, 32'hffffffff, 32'h00000000}};
  logic [4:0] eighths [8] = '{5'h08, 5'h04, 5'h02, 5'h00,
                              5'h00, 5'h01, 5'h00, 5'h00};
  logic [7:0] resv = 8'h98;

  dpa_ctrl u_dut (.sys_clk(sys_clk), .rst(rst), .bus(bus), .rdata(rdata),
                  .evt(evt), .policy(policy));
  dpa_cmd_src u_src (.sys_clk(sys_clk), .evt(evt));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (policy.boost_oldest === 1'b1) boosts++;

  task check(string name, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task wr(logic [7:0] a, logic [31:0] w);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus.wr <= 1'b0;
    #1;
  endtask : wr
  task rd(logic [7:0] a);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask : rd
  task give_verdict;
    $display("Checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict

  initial begin
    rst = 1'b1;
    bus = '0;
    repeat (8) @(posedge sys_clk);
    check("policy rst", {18'h0, policy}, 32'h000004a0);
    rst <= 1'b0;
    rd(8'h40);
    check("pc1 rst", d, 32'h0);
    for (int i = 0; i < 7; i++) begin
      wr(rows[i][0][7:0], rows[i][1]);
      rd(rows[i][0][7:0]);
      check("reg", d, rows[i][2]);
    end
    wr(8'h48, 32'h0);
    wr(8'h4c, 32'h0);
    for (int i = 0; i < 8; i++) begin
      wr(8'h3c, {13'h0, 3'(i), 13'h0, 3'(i)});
      check("init", {31'h0, policy.init_start}, 32'h1);
      check("rows", {27'h0, policy.row_bits}, 32'(9 + i));
      check("cover", {27'h0, policy.refresh_eighths}, 32'(eighths[i]));
      check("resv", {31'h0, policy.refresh_reserved}, 32'(resv[i]));
    end
    wr(8'h08, 32'h0);
    wr(8'h3c, 32'h00010007);
    check("init off", {31'h0, policy.init_start}, 32'h1);
    check("row off", {27'h0, policy.row_bits}, 32'h9);
    check("cover off", {27'h0, policy.refresh_eighths}, 32'h8);
    wr(8'h20, 32'h0);
    check("open row", {31'h0, policy.open_row_first}, 32'h0);
    wr(8'h20, 32'h00000010);
    check("open row", {31'h0, policy.open_row_first}, 32'h1);
    for (int n = 1; n <= 34; n++) begin
      u_src.issue(8'h01);
      @(posedge sys_clk);
      #1 check("boosts", boosts, n / 17);
    end
    rd(8'h40);
    check("pc1", d, 32'd34);
    rd(8'h44);
    check("pc2", d, 32'd34);
    wr(8'h40, 32'hffffffff);
    rd(8'h40);
    check("pc1 kept", d, 32'd34);
    // Counter one takes master 02 only, counter two register hits only
    wr(8'h48, 32'h40008000);
    wr(8'h4c, 32'h00070200);
    u_src.issue(8'h01);
    u_src.issue(8'h02);
    rd(8'h40);
    check("pc1 filt", d, 32'd35);
    rd(8'h44);
    check("pc2 filt", d, 32'd34);
    @(posedge sys_clk);
    rst <= 1'b1;
    @(posedge sys_clk);
    rst <= 1'b0;
    rd(8'h40);
    check("pc1 clear", d, 32'h0);
    give_verdict;
  end
  initial begin
    repeat (3000) @(posedge sys_clk);
    miscompares++;
    give_verdict;
  end
endmodule : tb_top

bind dpa_ctrl dpa_ctrl_chk u_chk (.sys_clk(sys_clk), .rst(rst), .bus(bus),
  .rdata(rdata), .evt(evt), .policy(policy));

// [design/dpa_consts.svh]
`ifndef DPA_CONSTS_SVH
`define DPA_CONSTS_SVH
// Register offsets
`define DPA_OFF_SDCR      8'h08
`define DPA_OFF_CFG2      8'h3c
`define DPA_OFF_AGING     8'h20
`define DPA_OFF_CNT_ONE   8'h40
`define DPA_OFF_CNT_TWO   8'h44
`define DPA_OFF_CNT_CFG   8'h48
`define DPA_OFF_CNT_FILT  8'h4c
// Field positions
`define DPA_BANK_POS_BIT  5
`define DPA_REFRESH_LSB   16
`define DPA_ROW_LSB       0
// Writable bits of the counter configuration
`define DPA_CNT_CFG_MASK  32'hc00fc00f
// Reset values
`define DPA_CFG2_RST      3'h0
`define DPA_ROW_RST       3'h0
`define DPA_AGING_RST     8'h00
`define DPA_CNT_CFG_RST   32'h00010000
`define DPA_CNT_FILT_RST  32'h00000000
`define DPA_COVER_RST     5'h08
// Row bits base
`define DPA_ROW_BASE      5'h09
`endif

// [design/dpa_ctrl.sv]
// Chosen here: the strobed register port and the address map.
`timescale 1ns/100ps
`include "dpa_consts.svh"

module dpa_ctrl (
  // Clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    rst,
  // Register bus
  input  wire dpa_pkg::dpa_bus_type    bus,
  output logic [31:0]                  rdata,
  // Command path events
  input  wire dpa_pkg::dpa_event_type  evt,
  // Scheduler policy
  output dpa_pkg::dpa_policy_type      policy
);
  import dpa_pkg::*;

  dpa_state_all_type s_reg;
  dpa_state_all_type s_next;

  // -------------------------------------------------------------
  // Filter match for one counter
  // -------------------------------------------------------------
  function automatic logic cnt_match(input logic       mst_en,
                                     input logic       reg_en,
                                     input logic [7:0] mst_id,
                                     input logic [3:0] region,
                                     input dpa_event_type e);
    logic ok;
    ok = 1'b1;
    if (mst_en && (e.master_id != mst_id)) begin
      ok = 1'b0;
    end
    if (mst_en && e.is_reg) begin
      ok = 1'b0;
    end
    if (reg_en && (region == 4'h0) && e.is_reg) begin
      ok = 1'b0;
    end
    if (reg_en && (region == 4'h7) && !e.is_reg) begin
      ok = 1'b0;
    end
    return ok;
  endfunction : cnt_match

  // -------------------------------------------------------------
  // Refresh coverage in eighths of the array
  // -------------------------------------------------------------
  function automatic logic [4:0] cover_eighths(input logic [2:0] code);
    logic [4:0] v;
    v = 5'h00;
    case (code)
      DPA_COVER_ALL:     v = 5'h08;
      DPA_COVER_TWO:     v = 5'h04;
      DPA_COVER_ONE:     v = 5'h02;
      DPA_COVER_HALF:    v = 5'h01;
      DPA_COVER_QUARTER: v = 5'h00;
      default:           v = 5'h00;
    endcase
    return v;
  endfunction : cover_eighths

  logic [8:0] limit;

  // -------------------------------------------------------------
  // Next state
  // -------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.policy.init_start = 1'b0;
    s_next.policy.boost_oldest = 1'b0;
    limit = {1'b0, s_reg.threshold} + 9'h001;

    if (bus.wr) begin
      case (bus.addr)
        `DPA_OFF_SDCR: begin
          s_next.internal_bank_position_sel =
            bus.wdata[`DPA_BANK_POS_BIT];
        end
        `DPA_OFF_CFG2: begin
          s_next.partial_array_refresh_select =
            bus.wdata[`DPA_REFRESH_LSB +: 3];
          s_next.row_size = bus.wdata[`DPA_ROW_LSB +: 3];
          s_next.policy.init_start = 1'b1;
        end
        `DPA_OFF_AGING: begin
          s_next.threshold = bus.wdata[7:0];
          s_next.xfer_cnt = 9'h000;
        end
        `DPA_OFF_CNT_CFG: begin
          s_next.perf_counter_config = bus.wdata & `DPA_CNT_CFG_MASK;
        end
        `DPA_OFF_CNT_FILT: begin
          s_next.perf_master_region_select = bus.wdata;
        end
        default: begin
        end
      endcase
    end

    // Effective config: defaults unless special addressing
    if (s_next.internal_bank_position_sel) begin
      s_next.policy.row_bits = `DPA_ROW_BASE
                               + {2'b00, s_next.row_size};
      s_next.policy.refresh_eighths =
        cover_eighths(s_next.partial_array_refresh_select);
      s_next.policy.refresh_reserved =
        (s_next.partial_array_refresh_select == 3'h3)
        || (s_next.partial_array_refresh_select == 3'h4)
        || (s_next.partial_array_refresh_select == 3'h7);
    end else begin
      s_next.policy.row_bits = `DPA_ROW_BASE;
      s_next.policy.refresh_eighths = `DPA_COVER_RST;
      s_next.policy.refresh_reserved = 1'b0;
    end

    s_next.policy.open_row_first = (s_next.threshold != 8'h00);

    case (s_reg.state)
      DPA_ST_IDLE: begin
        s_next.xfer_cnt = 9'h000;
        if (s_reg.threshold != 8'h00) begin
          s_next.state = DPA_ST_AGING;
        end
      end
      DPA_ST_AGING: begin
        if (s_reg.threshold == 8'h00) begin
          s_next.state = DPA_ST_IDLE;
        end else if (evt.xfer_done) begin
          if (s_reg.xfer_cnt + 9'h001 >= limit) begin
            s_next.state = DPA_ST_BOOST;
            s_next.policy.boost_oldest = 1'b1;
            s_next.xfer_cnt = 9'h000;
          end else begin
            s_next.xfer_cnt = s_reg.xfer_cnt + 9'h001;
          end
        end
      end
      DPA_ST_BOOST: begin
        s_next.state = DPA_ST_AGING;
        if (evt.xfer_done) begin
          s_next.xfer_cnt = 9'h001;
        end
      end
      default: s_next.state = DPA_ST_IDLE;
    endcase

    // Counters have no write path
    if (evt.xfer_done && cnt_match(s_reg.perf_counter_config[15],
        s_reg.perf_counter_config[14],
        s_reg.perf_master_region_select[15:8],
        s_reg.perf_master_region_select[3:0], evt)) begin
      s_next.perf_counter_one = s_reg.perf_counter_one + 32'h00000001;
    end
    if (evt.xfer_done && cnt_match(s_reg.perf_counter_config[31],
        s_reg.perf_counter_config[30],
        s_reg.perf_master_region_select[31:24],
        s_reg.perf_master_region_select[19:16], evt)) begin
      s_next.perf_counter_two = s_reg.perf_counter_two + 32'h00000001;
    end

    s_next.rdata = 32'h00000000;
    if (bus.rd) begin
      case (bus.addr)
        `DPA_OFF_SDCR: begin
          s_next.rdata[`DPA_BANK_POS_BIT] =
            s_reg.internal_bank_position_sel;
        end
        `DPA_OFF_CFG2: begin
          s_next.rdata[`DPA_REFRESH_LSB +: 3] =
            s_reg.partial_array_refresh_select;
          s_next.rdata[`DPA_ROW_LSB +: 3] = s_reg.row_size;
        end
        `DPA_OFF_AGING:    s_next.rdata[7:0] = s_reg.threshold;
        `DPA_OFF_CNT_ONE:  s_next.rdata = s_reg.perf_counter_one;
        `DPA_OFF_CNT_TWO:  s_next.rdata = s_reg.perf_counter_two;
        `DPA_OFF_CNT_CFG:  s_next.rdata = s_reg.perf_counter_config;
        `DPA_OFF_CNT_FILT: s_next.rdata = s_reg.perf_master_region_select;
        default:           s_next.rdata = 32'h00000000;
      endcase
    end
  end

  // -------------------------------------------------------------
  // State register
  // -------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_reg.state     <= DPA_ST_IDLE;
      s_reg.internal_bank_position_sel   <= 1'b0;
      s_reg.partial_array_refresh_select <= `DPA_CFG2_RST;
      s_reg.row_size                     <= `DPA_ROW_RST;
      s_reg.threshold                    <= `DPA_AGING_RST;
      s_reg.xfer_cnt                     <= 9'h000;
      s_reg.perf_counter_config          <= `DPA_CNT_CFG_RST;
      s_reg.perf_master_region_select    <= `DPA_CNT_FILT_RST;
      s_reg.perf_counter_one             <= 32'h00000000;
      s_reg.perf_counter_two             <= 32'h00000000;
      s_reg.rdata                        <= 32'h00000000;
      s_reg.policy                       <= {1'b0, 1'b0, `DPA_ROW_BASE,
                                             `DPA_COVER_RST, 1'b0, 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  // -------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------
  assign rdata  = s_reg.rdata;
  assign policy = s_reg.policy;
endmodule : dpa_ctrl

// [design/dpa_pkg.sv]
package dpa_pkg;
  typedef enum logic [2:0] {
    DPA_COVER_ALL     = 3'h0,
    DPA_COVER_TWO     = 3'h1,
    DPA_COVER_ONE     = 3'h2,
    DPA_COVER_HALF    = 3'h5,
    DPA_COVER_QUARTER = 3'h6
  } dpa_cover_type;

  typedef enum logic [2:0] {
    DPA_ST_IDLE  = 3'b001,
    DPA_ST_AGING = 3'b010,
    DPA_ST_BOOST = 3'b100
  } dpa_state_type;

  // Register bus request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } dpa_bus_type;

  // Scheduler policy view
  typedef struct packed {
    logic       open_row_first;
    logic       boost_oldest;
    logic [4:0] row_bits;
    logic [4:0] refresh_eighths;
    logic       refresh_reserved;
    logic       init_start;
  } dpa_policy_type;

  // Transfer event from the command path
  typedef struct packed {
    logic       xfer_done;
    logic       is_reg;
    logic [7:0] master_id;
  } dpa_event_type;

  typedef struct packed {
    dpa_state_type  state;
    logic           internal_bank_position_sel;
    logic [2:0]     partial_array_refresh_select;
    logic [2:0]     row_size;
    logic [7:0]     threshold;
    logic [8:0]     xfer_cnt;
    logic [31:0]    perf_counter_config;
    logic [31:0]    perf_master_region_select;
    logic [31:0]    perf_counter_one;
    logic [31:0]    perf_counter_two;
    logic [31:0]    rdata;
    dpa_policy_type policy;
  } dpa_state_all_type;
endpackage : dpa_pkg
